// ### rtl/init_loader_pkg.sv
/*
 * Constants for the reset-time register loader: register indexes,
 * flash layout, state encoding and bus widths.
 * Assumes a flash read port with a request pulse and a later valid strobe.
 */
package init_loader_pkg;
   localparam int unsigned DATA_W = 24;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned IDX_W = 5;
   localparam int unsigned FADDR_W = 5;
   // ==========================================================
   // register indexes; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_EVENT_FLAGS = 5'h00;
   localparam logic [IDX_W-1:0] IDX_LPOS = 5'h01;
   localparam logic [IDX_W-1:0] IDX_PPOS = 5'h02;
   localparam logic [IDX_W-1:0] IDX_SPEED = 5'h03;
   localparam logic [IDX_W-1:0] IDX_INSTR = 5'h04;
   localparam logic [IDX_W-1:0] IDX_TARGET = 5'h05;
   localparam logic [IDX_W-1:0] IDX_RAMP = 5'h09;
   localparam logic [IDX_W-1:0] IDX_TRIG_SETUP = 5'h0B;
   localparam logic [IDX_W-1:0] IDX_LAST_REG = 5'h12;
   localparam logic [IDX_W-1:0] IDX_STATUS = 5'h13;
   localparam logic [IDX_W-1:0] IDX_CTRL = 5'h14;
   localparam int unsigned NUM_REGS = 19;
   // registers cleared on leaving reset (event flags..instruction, sync instr, port2 ctrl, write helper)
   localparam logic [NUM_REGS-1:0] CLEAR_MASK = 19'h6041F;
   localparam logic [DATA_W-1:0] ZERO_VAL = 24'h000000;
   localparam int unsigned CTRL_RELOAD_BIT = 0;
   // ==========================================================
   // flash layout: pattern memory words, then the saved configuration file
   localparam int unsigned PAT_ENTRY_WORDS = 5;
   localparam int unsigned PAT_ENTRIES = 4;
   localparam int unsigned PAT_WORDS = PAT_ENTRY_WORDS * PAT_ENTRIES;
   localparam int unsigned CFG_WORDS = 6;
   localparam logic [FADDR_W-1:0] PAT_BASE = 5'h00;
   localparam logic [FADDR_W-1:0] CFG_BASE = 5'h14;
   // ==========================================================
   typedef enum logic [2:0] {
      ST_CLEAR, ST_PAT_REQ, ST_PAT_WAIT, ST_PARAM, ST_CFG_REQ, ST_CFG_WAIT, ST_READY
   } load_state_e;
endpackage

// ### rtl/reset_register_init_loader.sv
/*
 * Register set of one motion axis with its reset-time initialisation:
 * clears, pattern memory load from flash, parameter fill, config restore.
 * Assumes a synchronous register port and a flash port returning one word
 * per request on a valid strobe, each request answered before the next.
 */
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
module reset_register_init_loader (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [init_loader_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [init_loader_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [init_loader_pkg::DATA_W-1:0] reg_rdata,
   output logic ready,
   output logic flash_rd,
   output logic [init_loader_pkg::FADDR_W-1:0] flash_addr,
   input wire logic [init_loader_pkg::DATA_W-1:0] flash_rdata,
   input wire logic flash_rvalid
);
   // ==========================================================
   // reset release
   logic sync1_q;
   logic rst_sync_n;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         sync1_q <= 1'b1;
         rst_sync_n <= sync1_q;
      end
   end

   // ==========================================================
   // address decode
   function automatic logic [init_loader_pkg::IDX_W:0] decode(input logic [init_loader_pkg::ADDR_W-1:0] a);
      logic [init_loader_pkg::IDX_W-1:0] idx;
      idx = a[init_loader_pkg::IDX_W+1:2];
      decode = {(a[1:0] == 2'h0) && (a[init_loader_pkg::ADDR_W-1] == 1'b0), idx};
   endfunction

   // ==========================================================
   // loader state and registers
   init_loader_pkg::load_state_e state_q, state_d;
   logic [init_loader_pkg::DATA_W-1:0] regs_q [init_loader_pkg::NUM_REGS];
   logic [init_loader_pkg::DATA_W-1:0] regs_d [init_loader_pkg::NUM_REGS];
   logic [init_loader_pkg::DATA_W-1:0] pat_q [init_loader_pkg::PAT_WORDS];
   logic [init_loader_pkg::DATA_W-1:0] pat_d [init_loader_pkg::PAT_WORDS];
   logic [init_loader_pkg::FADDR_W-1:0] cnt_q, cnt_d;
   logic [init_loader_pkg::DATA_W-1:0] rdata_q, rdata_d;
   logic ready_q, ready_d;
   logic frd_q, frd_d;
   logic [init_loader_pkg::FADDR_W-1:0] faddr_q, faddr_d;
   logic [init_loader_pkg::IDX_W:0] wdec;
   logic [init_loader_pkg::IDX_W:0] rdec;

   always_comb begin
      wdec = decode(reg_addr);
      rdec = wdec;
      state_d = state_q;
      regs_d = regs_q;
      pat_d = pat_q;
      cnt_d = cnt_q;
      frd_d = 1'b0;
      faddr_d = faddr_q;
      rdata_d = init_loader_pkg::ZERO_VAL;
      unique case (state_q)
         init_loader_pkg::ST_CLEAR: begin
            for (int i = 0; i < init_loader_pkg::NUM_REGS; i++) begin
               if (init_loader_pkg::CLEAR_MASK[i]) begin
                  regs_d[i] = init_loader_pkg::ZERO_VAL;
               end
            end
            cnt_d = '0;
            state_d = init_loader_pkg::ST_PAT_REQ;
         end
         init_loader_pkg::ST_PAT_REQ: begin
            frd_d = 1'b1;
            faddr_d = init_loader_pkg::PAT_BASE + cnt_q;
            state_d = init_loader_pkg::ST_PAT_WAIT;
         end
         init_loader_pkg::ST_PAT_WAIT: begin
            if (flash_rvalid) begin
               pat_d[cnt_q] = flash_rdata;
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == 5'(init_loader_pkg::PAT_WORDS - 1)) begin
                  state_d = init_loader_pkg::ST_PARAM;
               end else begin
                  state_d = init_loader_pkg::ST_PAT_REQ;
               end
            end
         end
         init_loader_pkg::ST_PARAM: begin
            for (int i = 0; i < init_loader_pkg::PAT_ENTRY_WORDS; i++) begin
               regs_d[int'(init_loader_pkg::IDX_TARGET) + i] = pat_q[i];
            end
            cnt_d = '0;
            state_d = init_loader_pkg::ST_CFG_REQ;
         end
         init_loader_pkg::ST_CFG_REQ: begin
            frd_d = 1'b1;
            faddr_d = init_loader_pkg::CFG_BASE + cnt_q;
            state_d = init_loader_pkg::ST_CFG_WAIT;
         end
         init_loader_pkg::ST_CFG_WAIT: begin
            if (flash_rvalid) begin
               regs_d[init_loader_pkg::IDX_TRIG_SETUP + cnt_q] = flash_rdata;
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == 5'(init_loader_pkg::CFG_WORDS - 1)) begin
                  state_d = init_loader_pkg::ST_READY;
               end else begin
                  state_d = init_loader_pkg::ST_CFG_REQ;
               end
            end
         end
         init_loader_pkg::ST_READY: begin
            // writes only land once loading is over
            if (reg_wr && wdec[init_loader_pkg::IDX_W]) begin
               if (wdec[init_loader_pkg::IDX_W-1:0] <= init_loader_pkg::IDX_LAST_REG) begin
                  regs_d[wdec[init_loader_pkg::IDX_W-1:0]] = reg_wdata;
               end else if (wdec[init_loader_pkg::IDX_W-1:0] == init_loader_pkg::IDX_CTRL &&
                            reg_wdata[init_loader_pkg::CTRL_RELOAD_BIT]) begin
                  state_d = init_loader_pkg::ST_CLEAR;
               end
            end
         end
         default: begin
            state_d = init_loader_pkg::ST_CLEAR;
         end
      endcase
      if (reg_rd && rdec[init_loader_pkg::IDX_W]) begin
         if (rdec[init_loader_pkg::IDX_W-1:0] <= init_loader_pkg::IDX_LAST_REG) begin
            rdata_d = regs_q[rdec[init_loader_pkg::IDX_W-1:0]];
         end else if (rdec[init_loader_pkg::IDX_W-1:0] == init_loader_pkg::IDX_STATUS) begin
            rdata_d = {20'h00000, ready_q, 3'(state_q)};
         end
      end
      ready_d = (state_d == init_loader_pkg::ST_READY);
   end

   always_ff @(posedge clock or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state_q <= init_loader_pkg::ST_CLEAR;
         for (int i = 0; i < init_loader_pkg::NUM_REGS; i++) begin
            regs_q[i] <= init_loader_pkg::ZERO_VAL;
         end
         for (int i = 0; i < init_loader_pkg::PAT_WORDS; i++) begin
            pat_q[i] <= init_loader_pkg::ZERO_VAL;
         end
         cnt_q <= '0;
         rdata_q <= init_loader_pkg::ZERO_VAL;
         ready_q <= 1'b0;
         frd_q <= 1'b0;
         faddr_q <= '0;
      end else begin
         state_q <= state_d;
         regs_q <= regs_d;
         pat_q <= pat_d;
         cnt_q <= cnt_d;
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         frd_q <= frd_d;
         faddr_q <= faddr_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign ready = ready_q;
   assign flash_rd = frd_q;
   assign flash_addr = faddr_q;

   // ==========================================================
   // checks
   a_motion_cleared: assert property (@(posedge clock) disable iff (!rst_sync_n)
      $rose(ready_q) |-> regs_q[0] == 24'h000000 && regs_q[1] == 24'h000000 &&
         regs_q[2] == 24'h000000 && regs_q[3] == 24'h000000)
      else $error("motion registers not zero when ready");
   a_command_cleared: assert property (@(posedge clock) disable iff (!rst_sync_n)
      state_q == init_loader_pkg::ST_CLEAR |=> regs_q[4] == 24'h000000 && regs_q[10] == 24'h000000 &&
         regs_q[17] == 24'h000000 && regs_q[18] == 24'h000000)
      else $error("command registers not cleared");
   a_pattern_first: assert property (@(posedge clock) disable iff (!rst_sync_n)
      state_q == init_loader_pkg::ST_PARAM |-> cnt_q == 5'h14 && $past(flash_rvalid))
      else $error("parameters set before pattern copy finished");
   a_entry_zero_fill: assert property (@(posedge clock) disable iff (!rst_sync_n)
      state_q == init_loader_pkg::ST_PARAM |=> regs_q[5] == pat_q[0] && regs_q[7] == pat_q[2] &&
         regs_q[9] == pat_q[4])
      else $error("parameters differ from pattern entry zero");
   a_config_restore: assert property (@(posedge clock) disable iff (!rst_sync_n)
      state_q == init_loader_pkg::ST_CFG_WAIT && flash_rvalid && cnt_q == 5'h00
         |=> regs_q[11] == $past(flash_rdata))
      else $error("sync trigger setup not restored from flash");
   a_config_complete: assert property (@(posedge clock) disable iff (!rst_sync_n)
      $rose(ready_q) |-> cnt_q == 5'h06 && $past(faddr_q) == 5'h19)
      else $error("ready before whole saved file was read");
   a_write_holdoff: assert property (@(posedge clock) disable iff (!rst_sync_n)
      !ready_q && reg_wr && state_q != init_loader_pkg::ST_CLEAR |=> $stable(regs_q[1]) && $stable(regs_q[18]))
      else $error("register written while not ready");
   a_ready_state: assert property (@(posedge clock) disable iff (!rst_sync_n)
      ready_q == (state_q == init_loader_pkg::ST_READY))
      else $error("ready flag disagrees with loader state");
   a_restart_not_ready: assert property (@(posedge clock) disable iff (!rst_sync_n)
      state_q == init_loader_pkg::ST_CLEAR |=> !ready_q)
      else $error("ready while load sequence restarts");
   a_flash_pulse: assert property (@(posedge clock) disable iff (!rst_sync_n)
      frd_q |=> !frd_q)
      else $error("flash request longer than one cycle");
   a_copy_waits: assert property (@(posedge clock) disable iff (!rst_sync_n)
      state_q == init_loader_pkg::ST_PAT_WAIT && !flash_rvalid |=> state_q == init_loader_pkg::ST_PAT_WAIT)
      else $error("pattern copy moved on without a flash word");
   a_pattern_stored: assert property (@(posedge clock) disable iff (!rst_sync_n)
      state_q == init_loader_pkg::ST_PAT_WAIT && flash_rvalid && cnt_q == 5'h00 |=> pat_q[0] == $past(flash_rdata))
      else $error("first pattern word not stored from flash");
   a_config_waits: assert property (@(posedge clock) disable iff (!rst_sync_n)
      state_q == init_loader_pkg::ST_CFG_WAIT && !flash_rvalid |=> state_q == init_loader_pkg::ST_CFG_WAIT)
      else $error("config restore moved on without a flash word");
endmodule

// ### tb/flash_model.sv
/*
 * Behavioural flash holding the pattern words and the saved config file.
 * Assumes one outstanding request at a time; slow stretches the answer.
 */
`timescale 1ns/1ps
module flash_model (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic slow,
   input wire logic flash_rd,
   input wire logic [init_loader_pkg::FADDR_W-1:0] flash_addr,
   output logic [init_loader_pkg::DATA_W-1:0] flash_rdata,
   output logic flash_rvalid
);
   // ==========================================================
   // answer engine
   logic busy;
   logic [2:0] cnt;
   logic [init_loader_pkg::FADDR_W-1:0] a;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
         cnt <= 3'h0;
         a <= 5'h00;
         flash_rvalid <= 1'b0;
         flash_rdata <= 24'h000000;
      end else begin
         flash_rvalid <= 1'b0;
         // data line toggles whenever no word is presented
         flash_rdata <= ~flash_rdata;
         if (flash_rd) begin
            busy <= 1'b1;
            a <= flash_addr;
            cnt <= slow ? 3'h4 : 3'h0;
         end else if (busy) begin
            if (cnt == 3'h0) begin
               busy <= 1'b0;
               flash_rvalid <= 1'b1;
               flash_rdata <= {8'hA5, 8'h3C, 3'h0, a};
            end else begin
               cnt <= cnt - 3'h1;
            end
         end
      end
   end
endmodule

// ### tb/tb.sv
/*
 * Self-checking bench for the reset-time register loader.
 * Assumes the flash model in the same folder and the package constants.
 */
`timescale 1ns/1ps
module tb;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic slow = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [23:0] reg_wdata = 24'h000000;
   logic [23:0] reg_rdata, flash_rdata, d;
   logic ready, flash_rd, flash_rvalid;
   logic [4:0] flash_addr;
   int num_errors = 0;
   int n_tests = 0;
   int exp_addr = 0;
   initial forever #5 clock = ~clock;
   reset_register_init_loader i_reset_register_init_loader (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ready(ready),
      .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid));
   flash_model i_flash_model (.clock(clock), .rst_n(rst_n), .slow(slow), .flash_rd(flash_rd),
      .flash_addr(flash_addr), .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid));
   // ==========================================================
   // helpers
   function automatic logic [23:0] word(input int a);
      return {8'hA5, 8'h3C, 3'h0, 5'(a)};
   endfunction
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [23:0] v);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      d = reg_rdata;
   endtask
   task automatic do_reset;
      exp_addr = 0;
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
   endtask
   task automatic wait_ready;
      int k;
      for (k = 0; k < 400 && ready !== 1'b1; k++) @(negedge clock);
      chk("ready", 24'h000001, {23'h0, ready});
   endtask
   task automatic fill_all;
      int i;
      for (i = 0; i < 19; i++) wr(8'(i * 4), 24'hFFFFFF);
   endtask
   task automatic check_all;
      int i;
      for (i = 0; i < 19; i++) begin
         rd(8'(i * 4));
         if (i >= 5 && i <= 9) chk("param", word(i - 5), d);
         else if (i >= 11 && i <= 16) chk("config", word(i + 9), d);
         else chk("cleared", 24'h000000, d);
      end
   endtask
   // flash words must be fetched in pattern then config order
   always @(posedge clock) begin
      if (flash_rd === 1'b1) begin
         chk("flash_addr", 24'(exp_addr), 24'(flash_addr));
         exp_addr++;
      end
   end
   // ==========================================================
   // scenarios
   task automatic t_first_load;
      do_reset();
      repeat (4) @(negedge clock);
      chk("ready during load", 24'h000000, {23'h0, ready});
      rd(8'h4C);
      chk("status ready bit during load", 24'h000000, d & 24'h000008);
      wr(8'h48, 24'h123456);
      wait_ready();
      rd(8'h4C);
      chk("status when ready", 24'h00000E, d);
      check_all();
      chk("flash reads", 24'(26), 24'(exp_addr));
   endtask
   task automatic t_unsaved_lost;
      fill_all();
      rd(8'h10);
      chk("instr written", 24'hFFFFFF, d);
      rd(8'h2C);
      chk("sync setup written", 24'hFFFFFF, d);
      slow = 1'b1;
      do_reset();
      wait_ready();
      check_all();
      rd(8'h10);
      chk("instr cleared", 24'h000000, d);
   endtask
   task automatic t_restart;
      slow = 1'b0;
      fill_all();
      exp_addr = 0;
      wr(8'h50, 24'h000001);
      repeat (2) @(negedge clock);
      chk("ready on restart", 24'h000000, {23'h0, ready});
      wait_ready();
      check_all();
      rd(8'h7C);
      chk("unmapped", 24'h000000, d);
      @(negedge clock);
      chk("rdata after", 24'h000000, reg_rdata);
   endtask
   task automatic tally_and_finish;
      $display("errors %0d tests %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #60000;
      num_errors++;
      tally_and_finish();
   end
   initial begin
      t_first_load();
      t_unsaved_lost();
      t_restart();
      tally_and_finish();
   end
endmodule
